// file: core/config_startup_sequencer.sv
// Configuration sequencer: memory clear, data load, start-up phases, readback
// Operation
// - Start configuration after power-on reset and after program request.
// - Stages in order: clear memory, load data, start-up phase sequence.
// - Drive init pin low while configuration memory is cleared.
// - Wait after clearing until the init pin reads high.
// - Release init pin when clearing ends, signalling ready for data.
// - Hold global set/reset asserted throughout configuration.
// - Release done pin when configuration is complete.
// - On program request release, restart at memory clearing.
// - Release global set/reset once configuration reaches user mode.
// - Default: tristate released one start-up clock after done.
// - Default: write enable released one start-up clock after tristate.
// - After done, dual-purpose pins become user I/O gated by tristate.
// - Tristate and write-enable release may wait for chained done high.
// - Start-up may pause at a chosen phase for clock-manager lock.
// - Start-up clock: config clock, user clock or test clock.
// - Application may assert global set/reset and tristate itself.
// - Readback blocked at either protected security level.
// - Readback returns config data, registers, distributed and block RAM.
// - Register values captured at an application-chosen instant.
// - Serial chain forwarding supports bitstreams up to the length limit.
// - CRC error during loading drives the init pin low.
// - Done release phase selectable one to six, default four.
// - Write enable may wait for done input or keep its setting.
`timescale 1ns/1ns
`include "config_startup_cfg.svh"
module config_startup_sequencer
(
  input  wire logic                                      sys_clk,
  input  wire logic                                      sys_rst,
  input  wire logic                                      program_request_n,
  input  wire logic                                      init_in,
  output logic                                           init_out,
  output logic                                           init_oe,
  input  wire logic                                      done_in,
  output logic                                           done_out,
  output logic                                           done_oe,
  input  wire logic                                      config_clock,
  input  wire logic                                      config_data_in,
  output logic                                           chain_data_out,
  input  wire logic                                      user_clock,
  input  wire logic                                      test_clock,
  input  wire config_startup_pkg::startup_clock_select_t startup_clock_select,
  input  wire logic [2:0]                                done_release_phase,
  input  wire config_startup_pkg::release_mode_t         tristate_mode,
  input  wire logic [2:0]                                tristate_release_phase,
  input  wire config_startup_pkg::release_mode_t         write_enable_mode,
  input  wire logic [2:0]                                write_enable_release_phase,
  input  wire logic                                      chain_done_wait,
  input  wire logic [2:0]                                lock_wait_phase,
  input  wire logic [3:0]                                lock_wait_select,
  input  wire logic [3:0]                                clock_manager_lock,
  input  wire logic                                      crc_error,
  input  wire logic                                      user_set_reset,
  input  wire logic                                      user_tristate,
  input  wire logic [3:0]                                dual_pin_user_out,
  input  wire logic [3:0]                                dual_pin_user_oe,
  output logic [3:0]                                     dual_pin_out,
  output logic [3:0]                                     dual_pin_oe,
  output logic                                           user_io_enable,
  output logic                                           global_set_reset,
  output logic                                           global_tristate,
  output logic                                           global_write_enable,
  input  wire config_startup_pkg::security_t             security_level,
  input  wire logic                                      readback_request,
  input  wire config_startup_pkg::readback_sel_t         readback_select,
  input  wire logic                                      readback_capture,
  input  wire logic [31:0]                               app_register_state,
  input  wire logic [31:0]                               config_word,
  input  wire logic [31:0]                               dist_ram_word,
  input  wire logic [31:0]                               block_ram_word,
  output logic [31:0]                                    readback_data,
  output logic                                           readback_valid,
  output logic                                           readback_blocked,
  output config_startup_pkg::seq_state_t                 config_state,
  output logic [2:0]                                     startup_phase
);
  import config_startup_pkg::*;

  logic [6:0]  pin_meta_reg;
  logic [6:0]  pin_sync_reg;
  logic [2:0]  clk_prev_reg;
  logic [7:0]  prog_low_reg;
  logic [7:0]  clear_cnt_reg;
  logic [31:0] bit_cnt_reg;
  seq_state_t  state_reg;
  logic [2:0]  phase_reg;
  logic        done_rel_reg;
  logic        gts_rel_reg;
  logic        gwe_rel_reg;
  logic        gsr_reg;
  logic        gts_reg;
  logic        chain_reg;
  logic [3:0]  dual_out_reg;
  logic [31:0] capture_reg;
  logic [31:0] rb_data_reg;
  logic        rb_valid_reg;
  logic        rb_blocked_reg;

  logic        prog_s;
  logic        init_s;
  logic        done_s;
  logic        config_clock_edge;
  logic        stup_edge;
  logic        prog_armed;
  logic        own_loaded;
  logic [2:0]  phase_next;
  logic        wait_chain;
  logic        wait_lock;
  logic        advance;

  // Pins cross into sys_clk through two flops
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_meta_reg <= `CSS_PIN_SYNC_RST;
      pin_sync_reg <= `CSS_PIN_SYNC_RST;
    end
    else
    begin
      pin_meta_reg <= {program_request_n, init_in, done_in, config_clock, config_data_in, user_clock, test_clock};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      clk_prev_reg <= 3'h0;
    else
      clk_prev_reg <= {pin_sync_reg[`CSS_PIN_CONFIG_CLOCK], pin_sync_reg[`CSS_PIN_UCLK], pin_sync_reg[`CSS_PIN_TCK]};
  end

  assign prog_s = pin_sync_reg[`CSS_PIN_PROG];
  assign init_s = pin_sync_reg[`CSS_PIN_INIT];
  assign done_s = pin_sync_reg[`CSS_PIN_DONE];
  assign config_clock_edge = pin_sync_reg[`CSS_PIN_CONFIG_CLOCK] & ~clk_prev_reg[2];

  always_comb
  begin
    case (startup_clock_select)
      clk_user: stup_edge = pin_sync_reg[`CSS_PIN_UCLK] & ~clk_prev_reg[1];
      clk_test: stup_edge = pin_sync_reg[`CSS_PIN_TCK] & ~clk_prev_reg[0];
      default:  stup_edge = config_clock_edge;
    endcase
  end

  // Short glitches on the program pin are ignored
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      prog_low_reg <= 8'h00;
    else if (prog_s)
      prog_low_reg <= 8'h00;
    else if (!prog_armed)
      prog_low_reg <= prog_low_reg + 8'h01;
  end

  assign prog_armed = (prog_low_reg == 8'(`CSS_PROG_CYCLES));
  assign own_loaded = (bit_cnt_reg >= `CSS_OWN_FRAME_BITS);

  assign phase_next = phase_reg + 3'h1;
  assign wait_chain = chain_done_wait && !done_s &&
                      (phase_next == tristate_release_phase || phase_next == write_enable_release_phase);
  assign wait_lock = (phase_next == lock_wait_phase) &&
                     ((clock_manager_lock & lock_wait_select) != lock_wait_select);
  assign advance = (state_reg == st_startup) && stup_edge && !wait_chain && !wait_lock;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_reg <= st_clear;
    else if (prog_armed)
      state_reg <= st_prog_hold;
    else
    begin
      case (state_reg)
        st_prog_hold:
          if (prog_s)
            state_reg <= st_clear;
        st_clear:
          if (clear_cnt_reg == 8'(`CSS_CLEAR_CYCLES - 1))
            state_reg <= st_init_wait;
        st_init_wait:
          if (init_s)
            state_reg <= st_load;
        st_load:
          if (crc_error)
            state_reg <= st_error;
          else if (own_loaded)
            state_reg <= st_startup;
        st_startup:
          if (advance && phase_reg == `CSS_LAST_PHASE)
            state_reg <= st_user;
        default:
          state_reg <= state_reg;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      clear_cnt_reg <= 8'h00;
    else if (state_reg == st_clear)
      clear_cnt_reg <= clear_cnt_reg + 8'h01;
    else
      clear_cnt_reg <= 8'h00;
  end

  // Bits past the own frame go down the chain, up to the chain limit
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bit_cnt_reg <= 32'h0;
      chain_reg <= 1'b0;
    end
    else if (state_reg == st_clear || state_reg == st_prog_hold)
    begin
      bit_cnt_reg <= 32'h0;
      chain_reg <= 1'b0;
    end
    else if (config_clock_edge && state_reg != st_init_wait && bit_cnt_reg < `CSS_CHAIN_LIMIT)
    begin
      bit_cnt_reg <= bit_cnt_reg + 32'h1;
      if (own_loaded)
        chain_reg <= pin_sync_reg[`CSS_PIN_DIN];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      phase_reg <= 3'h0;
    else if (state_reg != st_startup && state_reg != st_user)
      phase_reg <= 3'h0;
    else if (advance && phase_reg != `CSS_LAST_PHASE)
      phase_reg <= phase_next;
  end

  // Release flags; defaults 4/5/6 give done, tristate, write enable one clock apart
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      done_rel_reg <= 1'b0;
      gts_rel_reg <= 1'b0;
      gwe_rel_reg <= 1'b0;
    end
    else if (state_reg == st_startup || state_reg == st_user)
    begin
      if (advance && phase_next == done_release_phase)
        done_rel_reg <= 1'b1;
      if (state_reg == st_user)
        done_rel_reg <= 1'b1;
      if (tristate_mode == rel_done ? done_s : (advance && phase_next == tristate_release_phase))
        gts_rel_reg <= 1'b1;
      if (write_enable_mode == rel_done ? done_s : (advance && phase_next == write_enable_release_phase))
        gwe_rel_reg <= 1'b1;
    end
    else
    begin
      done_rel_reg <= 1'b0;
      if (tristate_mode != rel_keep)
        gts_rel_reg <= 1'b0;
      if (write_enable_mode != rel_keep)
        gwe_rel_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gsr_reg <= 1'b1;
      gts_reg <= 1'b1;
    end
    else
    begin
      gsr_reg <= (state_reg != st_user) || user_set_reset;
      gts_reg <= !gts_rel_reg || user_tristate;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      dual_out_reg <= 4'h0;
    else
      dual_out_reg <= dual_pin_user_out;
  end

  // Readback capture and answer
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      capture_reg <= 32'h0;
    else if (readback_capture)
      capture_reg <= app_register_state;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rb_data_reg <= 32'h0;
      rb_valid_reg <= 1'b0;
      rb_blocked_reg <= 1'b0;
    end
    else
    begin
      rb_valid_reg <= readback_request && security_level == sec_none;
      rb_blocked_reg <= readback_request && security_level != sec_none;
      if (readback_request && security_level == sec_none)
      begin
        case (readback_select)
          rb_registers: rb_data_reg <= capture_reg;
          rb_dist_ram:  rb_data_reg <= dist_ram_word;
          rb_block_ram: rb_data_reg <= block_ram_word;
          default:      rb_data_reg <= config_word;
        endcase
      end
    end
  end

  assign init_out = 1'b0;
  assign init_oe = state_reg inside {st_clear, st_prog_hold, st_error};
  assign done_out = 1'b0;
  assign done_oe = !done_rel_reg;
  assign chain_data_out = chain_reg;
  assign user_io_enable = done_s;
  assign dual_pin_out = dual_out_reg;
  assign dual_pin_oe = (done_s && !gts_reg) ? dual_pin_user_oe : 4'h0;
  assign global_set_reset = gsr_reg;
  assign global_tristate = gts_reg;
  assign global_write_enable = gwe_rel_reg;
  assign readback_data = rb_data_reg;
  assign readback_valid = rb_valid_reg;
  assign readback_blocked = rb_blocked_reg;
  assign config_state = state_reg;
  assign startup_phase = phase_reg;
endmodule

// file: shared/config_startup_cfg.svh
// Constants of the configuration start-up sequencer
`ifndef CONFIG_STARTUP_CFG_SVH
`define CONFIG_STARTUP_CFG_SVH
`define CSS_CLK_PERIOD_NS 8
`define CSS_CLEAR_TIME_NS 2000
`define CSS_CLEAR_CYCLES ((`CSS_CLEAR_TIME_NS + `CSS_CLK_PERIOD_NS - 1) / `CSS_CLK_PERIOD_NS)
`define CSS_PROG_MIN_NS 300
`define CSS_PROG_CYCLES ((`CSS_PROG_MIN_NS + `CSS_CLK_PERIOD_NS - 1) / `CSS_CLK_PERIOD_NS)
`define CSS_CHAIN_LIMIT 32'hffffffe0
`define CSS_OWN_FRAME_BITS 32'h00000400
`define CSS_LAST_PHASE 3'h7
`define CSS_PIN_SYNC_RST 7'h40
`define CSS_PIN_PROG 6
`define CSS_PIN_INIT 5
`define CSS_PIN_DONE 4
`define CSS_PIN_CONFIG_CLOCK 3
`define CSS_PIN_DIN 2
`define CSS_PIN_UCLK 1
`define CSS_PIN_TCK 0
`endif

// file: shared/config_startup_pkg.sv
// Types of the configuration start-up sequencer
package config_startup_pkg;
  typedef enum logic [2:0] {st_prog_hold, st_clear, st_init_wait, st_load, st_error, st_startup, st_user} seq_state_t;
  typedef enum logic [1:0] {clk_config, clk_user, clk_test} startup_clock_select_t;
  typedef enum logic [1:0] {rel_phase, rel_done, rel_keep} release_mode_t;
  typedef enum logic [1:0] {sec_none, security_level_one, security_level_two} security_t;
  typedef enum logic [1:0] {rb_config, rb_registers, rb_dist_ram, rb_block_ram} readback_sel_t;
endpackage

// file: sim/config_startup_monitor.sv
// Port checker of the configuration start-up sequencer, bound into the design
`timescale 1ns/1ns
module config_startup_monitor
(
  input wire logic                           sys_clk,
  input wire logic                           sys_rst,
  input wire logic                           init_in,
  input wire logic                           init_oe,
  input wire logic                           done_oe,
  input wire logic [3:0]                     dual_pin_oe,
  input wire logic                           user_io_enable,
  input wire logic                           global_set_reset,
  input wire logic                           global_tristate,
  input wire logic                           global_write_enable,
  input wire config_startup_pkg::security_t  security_level,
  input wire logic                           readback_request,
  input wire logic                           readback_valid,
  input wire logic                           readback_blocked,
  input wire config_startup_pkg::seq_state_t config_state,
  input wire logic [2:0]                     startup_phase,
  input wire logic [2:0]                     done_release_phase
);
  import config_startup_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_clear_init_low: assert property (config_state == st_clear |-> init_oe)
    else $error("init pin not driven while clearing");
  a_init_wait_hold: assert property (
    !init_in [*3] ##0 config_state == st_init_wait |=> config_state == st_init_wait)
    else $error("left init wait while pin held low");
  a_load_init_free: assert property (config_state == st_load |-> !init_oe)
    else $error("init pin driven during load");
  a_gsr_held_config: assert property (
    config_state inside {st_clear, st_init_wait, st_load, st_startup} |-> global_set_reset)
    else $error("set/reset released during configuration");
  a_done_at_phase: assert property (
    $fell(done_oe) |-> config_state == st_startup && startup_phase == done_release_phase)
    else $error("done released at wrong phase");
  a_gsr_user_only: assert property ($fell(global_set_reset) |-> config_state == st_user)
    else $error("set/reset released outside user mode");
  a_tristate_after_done: assert property ($fell(global_tristate) |-> !done_oe && !$past(done_oe, 8))
    else $error("tristate released too early after done");
  a_we_after_tristate: assert property (
    $rose(global_write_enable) |-> !global_tristate && !$past(global_tristate, 8))
    else $error("write enable released too early");
  a_pins_gated: assert property (dual_pin_oe != 4'h0 |-> user_io_enable && !global_tristate)
    else $error("dual pin driven while gated");
  a_phase_single_step: assert property (
    $changed(startup_phase) |-> startup_phase == $past(startup_phase) + 3'h1 || startup_phase == 3'h0)
    else $error("phase jumped");
  a_readback_secured: assert property (
    readback_request && security_level != sec_none |=> readback_blocked && !readback_valid)
    else $error("readback not blocked");
endmodule
bind config_startup_sequencer config_startup_monitor mon (.*);

// file: sim/config_host_model.sv
// Configuration host: serial clock and data, open-drain wire levels
`timescale 1ns/1ns
module config_host_model
(
  input  wire logic run,
  input  wire logic init_hold,
  input  wire logic done_hold,
  input  wire logic init_oe,
  input  wire logic done_oe,
  output logic      config_clock,
  output logic      config_data_in,
  output logic      init_in,
  output logic      done_in
);
  // Pull-ups win unless some party pulls low
  assign init_in = !(init_oe || init_hold);
  assign done_in = !(done_oe || done_hold);
  initial
  begin
    config_clock = 1'b0;
    config_data_in = 1'b0;
  end
  // Clock stands still outside a frame; data changes on the falling edge
  always
  begin
    wait (run);
    #62 config_clock = 1'b1;
    #63 config_clock = 1'b0;
    config_data_in = ~config_data_in;
  end
endmodule

// file: sim/tb.sv
// Self-checking bench of the configuration start-up sequencer
`timescale 1ns/1ns
module tb;
  import config_startup_pkg::*;
  logic                  sys_clk, sys_rst, program_request_n, init_in, init_out, init_oe, done_in, done_out, done_oe;
  logic                  config_clock, config_data_in, chain_data_out, user_clock, test_clock, chain_done_wait;
  logic                  crc_error, user_set_reset, user_tristate, user_io_enable, global_set_reset, global_tristate;
  logic                  global_write_enable, readback_request, readback_capture, readback_valid, readback_blocked;
  logic                  run, init_hold, done_hold;
  logic [2:0]            done_release_phase, tristate_release_phase, write_enable_release_phase;
  logic [2:0]            lock_wait_phase, startup_phase;
  logic [3:0]            lock_wait_select, clock_manager_lock, dual_pin_user_out, dual_pin_user_oe, dual_pin_out, dual_pin_oe;
  logic [31:0]           app_register_state, config_word, dist_ram_word, block_ram_word, readback_data;
  startup_clock_select_t startup_clock_select;
  release_mode_t         tristate_mode, write_enable_mode;
  security_t             security_level;
  readback_sel_t         readback_select;
  seq_state_t            config_state;
  int                    err_count, cmp_count;

  config_startup_sequencer uut (.*);
  config_host_model host (.*);

  always #4 sys_clk = ~sys_clk;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_for(input seq_state_t s);
    for (int i = 0; i < 40000 && config_state !== s; i++)
      step(1);
    chk("state", 32'(s), 32'(config_state));
  endtask

  task automatic t_config(input logic hold, input logic chain);
    init_hold = hold;
    done_hold = chain;
    chain_done_wait = chain;
    step(245);
    chk("clear state", 32'(st_clear), 32'(config_state));
    chk("clear init", 1'b1, init_oe);
    chk("clear regs", 4'he, {done_oe, global_set_reset, global_tristate, global_write_enable});
    step(60);
    if (hold)
      chk("held init", 32'(st_init_wait), 32'(config_state));
    chk("init free", 1'b0, init_oe);
    init_hold = 1'b0;
    run = 1'b1;
    wait_for(st_load);
    wait_for(st_startup);
    for (int i = 0; i < 300 && done_oe !== 1'b0; i++)
      step(1);
    chk("done phase", 3'h4, startup_phase);
    chk("early pins", 4'h0, dual_pin_oe);
    if (chain)
    begin
      step(100);
      chk("chain stall", {3'h4, 1'b1, 1'b0}, {startup_phase, global_tristate, user_io_enable});
      done_hold = 1'b0;
    end
    for (int i = 0; i < 300 && global_tristate !== 1'b0; i++)
      step(1);
    chk("we held", 1'b0, global_write_enable);
    chk("user pins", dual_pin_user_oe, dual_pin_oe);
    for (int i = 0; i < 300 && global_write_enable !== 1'b1; i++)
      step(1);
    chk("we phase", 3'h6, startup_phase);
    wait_for(st_user);
    step(2);
    chk("user mode", 2'h1, {global_set_reset, user_io_enable});
    run = 1'b0;
    $display("config test done");
  endtask

  task automatic t_readback();
    logic [31:0] exp [4];
    app_register_state = 32'h5eed_0001;
    readback_capture = 1'b1;
    step(1);
    readback_capture = 1'b0;
    app_register_state = 32'h0bad_0bad;
    exp = '{config_word, 32'h5eed_0001, dist_ram_word, block_ram_word};
    for (int i = 0; i < 6; i++)
    begin
      security_level = i < 4 ? sec_none : security_t'(i - 3);
      readback_select = readback_sel_t'(i % 4);
      readback_request = 1'b1;
      step(1);
      readback_request = 1'b0;
      chk("rb flags", i < 4 ? 2'h2 : 2'h1, {readback_valid, readback_blocked});
      chk("rb data", exp[i < 4 ? i : 3], readback_data);
      step(1);
    end
    security_level = sec_none;
    $display("readback test done");
  endtask

  task automatic t_user();
    user_set_reset = 1'b1;
    user_tristate = 1'b1;
    dual_pin_user_out = 4'h5;
    step(2);
    chk("user gsr", 1'b1, global_set_reset);
    chk("user gts", 5'h10, {global_tristate, dual_pin_oe});
    chk("pin out", 4'h5, dual_pin_out);
    user_set_reset = 1'b0;
    user_tristate = 1'b0;
    step(2);
    chk("user gsr off", 1'b0, global_set_reset);
    chk("user gts off", 5'h06, {global_tristate, dual_pin_oe});
    $display("user test done");
  endtask

  task automatic t_prog();
    program_request_n = 1'b0;
    step(42);
    chk("prog hold", 32'(st_prog_hold), 32'(config_state));
    program_request_n = 1'b1;
    step(4);
    chk("restart", 32'(st_clear), 32'(config_state));
    $display("program test done");
  endtask

  task automatic t_crc();
    step(300);
    chk("load", 32'(st_load), 32'(config_state));
    crc_error = 1'b1;
    step(1);
    crc_error = 1'b0;
    step(2);
    chk("crc", {29'(st_error), 1'b1}, {29'(config_state), init_oe});
    $display("crc test done");
  endtask

  task automatic t_alt();
    startup_clock_select = clk_user;
    {lock_wait_phase, lock_wait_select, clock_manager_lock} = {3'h2, 4'h5, 4'h1};
    run = 1'b1;
    wait_for(st_startup);
    repeat (2)
    begin
      @(posedge config_clock);
      step(6);
      chk("chain out", config_data_in, chain_data_out);
    end
    chk("alt phase", 3'h0, startup_phase);
    repeat (4)
    begin
      user_clock = 1'b1;
      step(8);
      user_clock = 1'b0;
      step(8);
    end
    chk("lock stall", 3'h1, startup_phase);
    clock_manager_lock = 4'h5;
    startup_clock_select = clk_test;
    repeat (5)
    begin
      test_clock = 1'b1;
      step(8);
      test_clock = 1'b0;
      step(8);
    end
    chk("test clock", 4'hd, {startup_phase, global_write_enable});
    run = 1'b0;
    startup_clock_select = clk_config;
    $display("startup clock test done");
  endtask

  task automatic close_out();
    $display("Checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    {sys_clk, run, init_hold, done_hold, user_clock, test_clock, chain_done_wait, crc_error} = '0;
    {user_set_reset, user_tristate, readback_request, readback_capture, err_count, cmp_count} = '0;
    {lock_wait_select, clock_manager_lock, lock_wait_phase} = '0;
    {dual_pin_user_out, dual_pin_user_oe} = 8'h96;
    {sys_rst, program_request_n} = 2'h3;
    {done_release_phase, tristate_release_phase, write_enable_release_phase} = {3'h4, 3'h5, 3'h6};
    startup_clock_select = clk_config;
    tristate_mode = rel_phase;
    write_enable_mode = rel_phase;
    security_level = sec_none;
    readback_select = rb_config;
    {app_register_state, config_word} = {32'h0, 32'hc0f1_6a01};
    {dist_ram_word, block_ram_word} = {32'hd157_0002, 32'hb10c_0003};
    step(3);
    sys_rst = 1'b0;
    t_config(1'b0, 1'b0);
    t_readback();
    t_user();
    t_prog();
    t_config(1'b1, 1'b1);
    write_enable_mode = rel_keep;
    t_prog();
    chk("we kept", 1'b1, global_write_enable);
    write_enable_mode = rel_phase;
    t_crc();
    t_prog();
    t_alt();
    close_out();
  end

  initial
  begin
    #600000;
    err_count++;
    close_out();
  end
endmodule
